// file: core/pal_exec.sv
// execution of pointer add literal and pointer two add and return
// assumes insn_valid marks a fetched word that executes this cycle
`default_nettype none
module pal_exec
  import pal_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          insn_valid,
  input  wire logic [pal_pkg::INSN_W-1:0]    insn,
  input  wire logic [pal_pkg::PC_W-1:0]      return_stack_top,
  input  wire logic                          pc_load_en_in,
  input  wire logic [pal_pkg::PC_W-1:0]      pc_load_val,
  output logic                               insn_taken,
  output logic                               fetch_stall,
  output logic                               return_stack_pop,
  output logic                               status_write_en,
  output logic      [pal_pkg::PTR_W-1:0]     indirect_pointer_0,
  output logic      [pal_pkg::PTR_W-1:0]     indirect_pointer_1,
  output logic      [pal_pkg::PTR_W-1:0]     indirect_pointer_two,
  output logic      [pal_pkg::PC_W-1:0]      pc,
  output logic                               pc_reloaded
);
  import pal_pkg::*;

  typedef struct packed {
    pal_phase_t              phase;
    logic [PTR_W-1:0]        ptr0;
    logic [PTR_W-1:0]        ptr1;
    logic [PTR_W-1:0]        ptr2;
    logic [PC_W-1:0]         pc;
    logic                    reloaded;
  } pal_state_t;

  pal_state_t        state;
  pal_state_t        next_state;
  logic              is_ptr_add;
  logic [SEL_W-1:0]  sel;
  logic [LIT_W-1:0]  lit;
  logic [PTR_W-1:0]  chosen;
  logic [PTR_W-1:0]  sum;

  assign is_ptr_add = insn_valid && (state.phase == PAL_EXEC) && (insn[OPC_HI:OPC_LO] == OPC_PTR_ADD);
  assign sel        = insn[SEL_HI:SEL_LO];
  assign lit        = insn[LIT_HI:LIT_LO];

  always_comb
  begin
    unique case (sel)
      2'h0:    chosen = state.ptr0;
      2'h1:    chosen = state.ptr1;
      default: chosen = state.ptr2;
    endcase
  end

  pal_adder u_adder
  (
    .ptr_in  (chosen),
    .literal (lit),
    .sum     (sum)
  );

  always_comb
  begin
    next_state          = state;
    next_state.reloaded = 1'b0;
    unique case (state.phase)
      PAL_EXEC:
      begin
        if (is_ptr_add)
        begin
          unique case (sel)
            2'h0: next_state.ptr0 = sum;
            2'h1: next_state.ptr1 = sum;
            2'h2: next_state.ptr2 = sum;
            default:
            begin
              next_state.ptr2     = sum;
              next_state.pc       = return_stack_top;
              next_state.reloaded = 1'b1;
              next_state.phase    = PAL_FLUSH;
            end
          endcase
        end
        else if (pc_load_en_in)
        begin
          next_state.pc = pc_load_val;
        end
      end
      PAL_FLUSH:
      begin
        next_state.phase = PAL_EXEC;
      end
      default:
      begin
        next_state.phase = PAL_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state.phase    <= PAL_EXEC;
      state.ptr0     <= PTR_RESET;
      state.ptr1     <= PTR_RESET;
      state.ptr2     <= PTR_RESET;
      state.pc       <= PC_RESET;
      state.reloaded <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign insn_taken           = is_ptr_add;
  assign fetch_stall          = (state.phase == PAL_FLUSH);
  assign return_stack_pop     = is_ptr_add && (sel == SEL_RETURN);
  assign status_write_en      = 1'b0;
  assign indirect_pointer_0   = state.ptr0;
  assign indirect_pointer_1   = state.ptr1;
  assign indirect_pointer_two = state.ptr2;
  assign pc                   = state.pc;
  assign pc_reloaded          = state.reloaded;
endmodule : pal_exec
`default_nettype wire

// file: core/pal_pkg.sv
// constants for the pointer add literal execution block
// assumes a 16-bit instruction word and 12-bit indirect pointers
`default_nettype none
package pal_pkg;
  localparam int          PTR_W          = 12;
  localparam int          PC_W           = 21;
  localparam int          INSN_W         = 16;
  localparam int          LIT_W          = 6;
  localparam int          SEL_W          = 2;
  localparam int          NUM_PTR        = 3;
  localparam int          OPC_HI         = 15;
  localparam int          OPC_LO         = 8;
  localparam int          SEL_HI         = 7;
  localparam int          SEL_LO         = 6;
  localparam int          LIT_HI         = 5;
  localparam int          LIT_LO         = 0;
  localparam logic [7:0]  OPC_PTR_ADD    = 8'hE8;
  localparam logic [1:0]  SEL_RETURN     = 2'h3;
  localparam logic [1:0]  SEL_PTR_TWO    = 2'h2;
  localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [PC_W-1:0]  PC_RESET  = 21'h00000;

  typedef enum logic [1:0] {
    PAL_EXEC  = 2'b01,
    PAL_FLUSH = 2'b10
  } pal_phase_t;
endpackage : pal_pkg
`default_nettype wire

// file: core/pal_adder.sv
// full-width pointer adder with a zero-extended literal
// assumes purely combinational use by the execution block
`default_nettype none
module pal_adder
  import pal_pkg::*;
(
  input  wire logic [pal_pkg::PTR_W-1:0] ptr_in,
  input  wire logic [pal_pkg::LIT_W-1:0] literal,
  output logic      [pal_pkg::PTR_W-1:0] sum
);
  import pal_pkg::*;

  assign sum = ptr_in + {{(PTR_W-LIT_W){1'b0}}, literal};
endmodule : pal_adder
`default_nettype wire

// file: verif/pal_exec_properties.sv
// assertions on the pal_exec ports
// assumes it is bound onto pal_exec
`default_nettype none
module pal_props
  import pal_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              insn_valid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [PC_W-1:0]   return_stack_top,
  input wire logic              insn_taken,
  input wire logic              fetch_stall,
  input wire logic              return_stack_pop,
  input wire logic              status_write_en,
  input wire logic [PTR_W-1:0]  indirect_pointer_0,
  input wire logic [PTR_W-1:0]  indirect_pointer_1,
  input wire logic [PTR_W-1:0]  indirect_pointer_two,
  input wire logic [PC_W-1:0]   pc
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire sel3 = insn_taken && insn[7:6] == 2'h3;
  a_add_ptr_two: assert property (insn_taken && insn[7:6] == 2'h2 |=>
    indirect_pointer_two == $past(indirect_pointer_two) + $past(insn[5:0])) else $error("sum wrong");
  a_taken_decode: assert property (insn_valid && insn[15:8] == 8'hE8 && !fetch_stall |-> insn_taken)
    else $error("add not taken");
  a_return_pc: assert property (sel3 |=> pc == $past(return_stack_top) && fetch_stall)
    else $error("return pc wrong");
  a_stall_once: assert property (fetch_stall |=> !fetch_stall) else $error("stall too long");
  a_stall_refuses: assert property (fetch_stall |-> !insn_taken) else $error("taken in stall");
  a_sel3_pops: assert property (sel3 |-> return_stack_pop) else $error("no pop");
  a_others_kept: assert property (sel3 |=> $stable(indirect_pointer_0) && $stable(indirect_pointer_1))
    else $error("other pointer changed");
  a_flags_quiet: assert property (!status_write_en) else $error("flags written");
  c_ret: cover property (sel3);
  c_add: cover property (insn_taken && insn[7:6] == 2'h0);
  c_refused: cover property (fetch_stall && insn_valid);
endmodule : pal_props
bind pal_exec pal_props u_pal_props (.*);
`default_nettype wire

// file: verif/tb_pal_exec.sv
// directed bench for pal_exec
// assumes pal_pkg and pal_exec are compiled first
`default_nettype none
module tb_pal_exec;
  import pal_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst = 1, insn_valid = 0, pc_load_en_in = 0;
  logic [15:0] insn = 16'h0000;
  logic [20:0] return_stack_top = 21'h00000, pc_load_val = 21'h00000, pc;
  logic [11:0] indirect_pointer_0, indirect_pointer_1, indirect_pointer_two;
  logic insn_taken, fetch_stall, return_stack_pop, status_write_en, pc_reloaded;
  int num_errors = 0, checks_done = 0;
  pal_exec u_pal_exec (.*);
  always #12.5 clock = ~clock;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic issue(input logic v, input logic [15:0] w);
    @(posedge clock);
    #1;
    insn_valid = v;
    insn = w;
    #1;
  endtask : issue
  task automatic t_add;
    for (int f = 0; f < 3; f++)
    begin
      issue(1'b1, {8'hE8, f[1:0], 6'h3F});
      chk("taken", insn_taken, 1'b1);
      issue(1'b1, {8'hE8, f[1:0], 6'h3F});
    end
    issue(1'b0, 16'h0000);
    chk("ptr0", indirect_pointer_0, 12'h07E);
    chk("ptr1", indirect_pointer_1, 12'h07E);
    chk("ptr2", indirect_pointer_two, 12'h07E);
    chk("flags", status_write_en, 1'b0);
  endtask : t_add
  task automatic t_ret;
    return_stack_top = 21'h1ABCDE;
    // a competing pc load in the same cycle must lose to the return
    pc_load_en_in = 1'b1;
    pc_load_val = 21'h0AAAA;
    issue(1'b1, {8'hE8, 2'h3, 6'h23});
    chk("pop", return_stack_pop, 1'b1);
    issue(1'b1, {8'hE8, 2'h0, 6'h01});
    chk("stall", fetch_stall, 1'b1);
    chk("refused", insn_taken, 1'b0);
    chk("pc", pc, 21'h1ABCDE);
    chk("reloaded", pc_reloaded, 1'b1);
    chk("ptr2", indirect_pointer_two, 12'h0A1);
    pc_load_en_in = 1'b0;
    issue(1'b0, 16'h0000);
    chk("ptr0", indirect_pointer_0, 12'h07E);
    chk("ptr1", indirect_pointer_1, 12'h07E);
    chk("resume", fetch_stall, 1'b0);
    chk("reload done", pc_reloaded, 1'b0);
    pc_load_en_in = 1'b1;
    pc_load_val = 21'h00055;
    issue(1'b0, 16'h0000);
    pc_load_en_in = 1'b0;
    chk("pc load", pc, 21'h00055);
  endtask : t_ret
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    rst = 0;
    t_add;
    t_ret;
    report_and_stop;
  end
  initial
  begin
    #5000;
    num_errors++;
    report_and_stop;
  end
endmodule : tb_pal_exec
`default_nettype wire
